/* File: include/pslv_pkg.sv */
package pslv_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned SYNC_STAGES = 2;

    // Bit positions of the slave port control byte.
    localparam int unsigned IBF_BIT = 7;
    localparam int unsigned OBF_BIT = 6;
    localparam int unsigned OVF_BIT = 5;
    localparam int unsigned MODE_BIT = 4;

    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] OE_N_OFF = 8'hff;
    localparam logic [3:0] RSVD_VAL = 4'h0;
    localparam logic MODE_RST = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [2:0] PIN_RST = 3'h7;

    // Control pin order within the strobe bundle.
    localparam int unsigned RD_PIN = 0;
    localparam int unsigned WR_PIN = 1;
    localparam int unsigned CS_PIN = 2;

    typedef struct packed {
        logic input_full_flag;
        logic output_full_flag;
        logic input_overflow_flag;
        logic port_mode_select;
        logic [3:0] rsvd;
    } pslv_ctrl_t;

    typedef struct packed {
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pslv_cpu_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_READ
    } pslv_state_t;

endpackage

/* File: verilog/pslv_port.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - With the mode select bit set the 8-bit data pins act as a slave port, otherwise as plain I/O.
// - External reads and writes are taken asynchronously to the core clock under the strobe pins.
// - The external processor reads and writes one shared 8-bit data latch.
// - On the large package the slave port works only while no external program memory is used.
// - In slave mode control pin 0 is the read strobe, pin 1 the write strobe, pin 2 the chip select.
// - A write starts when select and write strobe are first seen low and ends when either is high.
// - When a write ends both the interrupt flag and the input-full flag are set.
// - When select and read strobe are first seen low the latch is driven out and output-full is set.
// - A core write to the latch during a read is driven out at once but leaves output-full alone.
// - When select or read strobe is seen high the pins float again and the interrupt flag is set.
// - A write arriving while input-full is set raises overflow, which only software clears.
// - Control byte holds input-full at 7, output-full at 6, overflow at 5, mode at 4, zeros below.
module pslv_port (
    input wire logic clock,
    input wire logic rstn,
    input wire pslv_pkg::pslv_cpu_t cpu_req,
    input wire logic mode_wr,
    input wire logic mode_wdata,
    input wire logic ovf_clr,
    input wire logic irq_clr,
    input wire logic large_pkg,
    input wire logic ext_prog_mem,
    input wire logic [2:0] ctl_pin_in,
    input wire logic [7:0] data_pin_in,
    output logic [7:0] data_pin_out,
    output logic [7:0] data_pin_oe_n,
    output logic [7:0] cpu_rdata,
    output pslv_pkg::pslv_ctrl_t slave_port_control,
    output logic slave_port_irq_flag
);

    logic [2:0] ctl_meta_q;
    logic [2:0] ctl_sync_q;
    logic [7:0] dat_meta_q;
    logic [7:0] dat_sync_q;
    pslv_pkg::pslv_state_t st_q;
    pslv_pkg::pslv_state_t st_d;
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic [7:0] oe_n_d;
    logic mode_q;
    logic ibf_q;
    logic obf_q;
    logic ovf_q;
    logic irq_q;
    logic ibf_d;
    logic obf_d;
    logic ovf_d;
    logic irq_d;

    // Two-stage synchronisers; only the second stage is ever looked at.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_meta_q <= pslv_pkg::PIN_RST;
            ctl_sync_q <= pslv_pkg::PIN_RST;
            dat_meta_q <= pslv_pkg::LATCH_RST;
            dat_sync_q <= pslv_pkg::LATCH_RST;
        end else begin
            ctl_meta_q <= ctl_pin_in;
            ctl_sync_q <= ctl_meta_q;
            dat_meta_q <= data_pin_in;
            dat_sync_q <= dat_meta_q;
        end
    end

    wire rd_n_s = ctl_sync_q[pslv_pkg::RD_PIN];
    wire wr_n_s = ctl_sync_q[pslv_pkg::WR_PIN];
    wire cs_n_s = ctl_sync_q[pslv_pkg::CS_PIN];

    // On the large package the port is withheld while external program memory owns the bus.
    wire port_on = mode_q && !(large_pkg && ext_prog_mem);
    wire wr_act = port_on && !cs_n_s && !wr_n_s;
    wire rd_act = port_on && !cs_n_s && !rd_n_s;
    wire in_write = st_q == pslv_pkg::ST_WRITE;
    wire in_read = st_q == pslv_pkg::ST_READ;
    wire in_idle = st_q == pslv_pkg::ST_IDLE;
    wire wr_start = in_idle && wr_act;
    wire rd_start = in_idle && !wr_act && rd_act;
    wire wr_end = in_write && !wr_act;
    wire rd_end = in_read && !rd_act;

    always_comb begin
        st_d = st_q;
        case (st_q)
            pslv_pkg::ST_IDLE: begin
                if (wr_start) begin
                    st_d = pslv_pkg::ST_WRITE;
                end else if (rd_start) begin
                    st_d = pslv_pkg::ST_READ;
                end
            end
            pslv_pkg::ST_WRITE: begin
                if (wr_end) begin
                    st_d = pslv_pkg::ST_IDLE;
                end
            end
            pslv_pkg::ST_READ: begin
                if (rd_end) begin
                    st_d = pslv_pkg::ST_IDLE;
                end
            end
            default: begin
                st_d = pslv_pkg::ST_IDLE;
            end
        endcase
    end

    // One latch serves both directions; an external write samples the bus every
    // cycle of the cycle so the value seen last before the strobe rises is kept.
    always_comb begin
        latch_d = latch_q;
        if (in_write && wr_act) begin
            latch_d = dat_sync_q;
        end else if (cpu_req.wr) begin
            latch_d = cpu_req.wdata;
        end
    end

    // Pins drive only from the first seen read until its end.
    always_comb begin
        oe_n_d = pslv_pkg::OE_N_OFF;
        if (rd_start || (in_read && rd_act)) begin
            oe_n_d = ~pslv_pkg::OE_N_OFF;
        end
        if (rd_end) begin
            oe_n_d = pslv_pkg::OE_N_OFF;
        end
    end

    // Hardware sets win over software clears in the same cycle.
    always_comb begin
        ibf_d = ibf_q;
        if (cpu_req.rd) begin
            ibf_d = 1'b0;
        end
        if (wr_end) begin
            ibf_d = 1'b1;
        end
        ovf_d = ovf_q;
        if (ovf_clr) begin
            ovf_d = 1'b0;
        end
        if (wr_end && ibf_q) begin
            ovf_d = 1'b1;
        end
        obf_d = obf_q;
        if (cpu_req.wr && !in_read) begin
            obf_d = 1'b1;
        end
        if (rd_start) begin
            obf_d = 1'b1;
        end
        if (!mode_q) begin
            obf_d = 1'b0;
        end
        irq_d = irq_q;
        if (irq_clr) begin
            irq_d = 1'b0;
        end
        if (wr_end || rd_end) begin
            irq_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= pslv_pkg::ST_IDLE;
            latch_q <= pslv_pkg::LATCH_RST;
            data_pin_oe_n <= pslv_pkg::OE_N_OFF;
            mode_q <= pslv_pkg::MODE_RST;
            ibf_q <= pslv_pkg::FLAG_RST;
            obf_q <= pslv_pkg::FLAG_RST;
            ovf_q <= pslv_pkg::FLAG_RST;
            irq_q <= pslv_pkg::FLAG_RST;
        end else begin
            st_q <= st_d;
            latch_q <= latch_d;
            data_pin_oe_n <= oe_n_d;
            if (mode_wr) begin
                mode_q <= mode_wdata;
            end
            ibf_q <= ibf_d;
            obf_q <= obf_d;
            ovf_q <= ovf_d;
            irq_q <= irq_d;
        end
    end

    // Outputs copy the next state, so they change at the same edge as the flags.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            data_pin_out <= pslv_pkg::LATCH_RST;
            cpu_rdata <= pslv_pkg::LATCH_RST;
            slave_port_control <= '0;
            slave_port_irq_flag <= pslv_pkg::FLAG_RST;
        end else begin
            data_pin_out <= latch_d;
            cpu_rdata <= latch_d;
            slave_port_control.input_full_flag <= ibf_d;
            slave_port_control.output_full_flag <= obf_d;
            slave_port_control.input_overflow_flag <= ovf_d;
            slave_port_control.port_mode_select <= mode_wr ? mode_wdata : mode_q;
            slave_port_control.rsvd <= pslv_pkg::RSVD_VAL;
            slave_port_irq_flag <= irq_d;
        end
    end

    chk_write_end_flags: assert property (@(posedge clock) disable iff (!rstn)
        wr_end |=> slave_port_irq_flag && slave_port_control.input_full_flag)
        else $error("write end did not set both flags");

    chk_read_drive: assert property (@(posedge clock) disable iff (!rstn)
        rd_start |=> data_pin_oe_n == 8'h00 && slave_port_control.output_full_flag)
        else $error("read start did not drive pins and set output full");

    chk_read_release: assert property (@(posedge clock) disable iff (!rstn)
        rd_end |=> data_pin_oe_n == 8'hff && slave_port_irq_flag)
        else $error("read end did not float pins and set interrupt");

    chk_new_data_out: assert property (@(posedge clock) disable iff (!rstn)
        in_read && rd_act && cpu_req.wr |=> data_pin_out == $past(cpu_req.wdata)
        && slave_port_control.output_full_flag == $past(obf_q))
        else $error("core write during read mishandled");

    chk_overflow_set: assert property (@(posedge clock) disable iff (!rstn)
        wr_end && ibf_q |=> slave_port_control.input_overflow_flag)
        else $error("overflow not raised on write over unread word");

    chk_overflow_hold: assert property (@(posedge clock) disable iff (!rstn)
        ovf_q && !ovf_clr |=> ovf_q)
        else $error("overflow cleared without software");

    chk_rsvd_zero: assert property (@(posedge clock) disable iff (!rstn)
        slave_port_control.rsvd == 4'h0)
        else $error("reserved control bits not zero");

    chk_ibf_clear: assert property (@(posedge clock) disable iff (!rstn)
        cpu_req.rd && !wr_end |=> !slave_port_control.input_full_flag)
        else $error("core read did not clear input full");

    chk_gpio_float: assert property (@(posedge clock) disable iff (!rstn)
        !port_on |=> data_pin_oe_n == 8'hff)
        else $error("pins driven outside slave mode");

    chk_sync_latency: assert property (@(posedge clock) disable iff (!rstn)
        (in_idle && port_on && !mode_wr && ctl_pin_in == 3'h1)[*3] |=> in_write)
        else $error("write not seen after two sync stages");

    chk_ext_mem_off: assert property (@(posedge clock) disable iff (!rstn)
        large_pkg && ext_prog_mem && in_idle |=> in_idle)
        else $error("slave port active with external memory");

    cov_write: cover property (@(posedge clock) disable iff (!rstn) wr_end);
    cov_read: cover property (@(posedge clock) disable iff (!rstn) rd_end);
    cov_overflow: cover property (@(posedge clock) disable iff (!rstn) wr_end && ibf_q);
    cov_wr_in_read: cover property (@(posedge clock) disable iff (!rstn) in_read && cpu_req.wr);

endmodule // pslv_port

/* File: testbench/pslv_host_model.sv */
`timescale 1ns/10ps
module pslv_host_model (
    input wire logic clock,
    input wire logic [7:0] bus_in,
    output logic [2:0] ctl_n,
    output logic [7:0] bus_out
);
    logic [7:0] last_q;
    initial begin
        ctl_n = pslv_pkg::PIN_RST;
        bus_out = 8'h00;
        last_q = 8'h00;
    end
    // Data is held a few cycles past the strobe, then the released bus shows the inverse.
    task automatic write_cycle(input logic [7:0] data, input int hold);
        @(posedge clock);
        #1;
        bus_out = data;
        last_q = data;
        ctl_n = 3'b001;
        repeat (hold) @(posedge clock);
        #1 ctl_n = 3'b111;
        repeat (4) @(posedge clock);
        #1 bus_out = ~last_q;
        @(posedge clock);
        #1;
    endtask
    task automatic read_cycle(input int hold, output logic [7:0] data);
        @(posedge clock);
        #1 ctl_n = 3'b010;
        repeat (hold) @(posedge clock);
        data = bus_in;
        #1 ctl_n = 3'b111;
        repeat (5) @(posedge clock);
        #1;
    endtask
endmodule // pslv_host_model

/* File: testbench/pslv_port_tb.sv */
`timescale 1ns/10ps
module pslv_port_tb;
    logic clock, rstn, mode_wr, mode_wdata, ovf_clr, irq_clr, large_pkg, ext_prog_mem;
    pslv_pkg::pslv_cpu_t cpu_req;
    logic [2:0] ctl_pin_in;
    logic [7:0] data_pin_in, data_pin_out, data_pin_oe_n, cpu_rdata, host_bus, rd_data;
    pslv_pkg::pslv_ctrl_t slave_port_control;
    logic slave_port_irq_flag;
    int err_count = 0;
    int tests_run = 0;
    // Each pin is driven by the port while its enable is low, by the host model otherwise.
    assign data_pin_in = (data_pin_out & ~data_pin_oe_n) | (host_bus & data_pin_oe_n);
    pslv_port u_dut (.clock(clock), .rstn(rstn), .cpu_req(cpu_req), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata), .ovf_clr(ovf_clr), .irq_clr(irq_clr), .large_pkg(large_pkg),
        .ext_prog_mem(ext_prog_mem), .ctl_pin_in(ctl_pin_in), .data_pin_in(data_pin_in),
        .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n), .cpu_rdata(cpu_rdata),
        .slave_port_control(slave_port_control), .slave_port_irq_flag(slave_port_irq_flag));
    pslv_host_model u_host (.clock(clock), .bus_in(data_pin_in), .ctl_n(ctl_pin_in),
        .bus_out(host_bus));
    initial clock = 1'b0;
    always #20 clock = ~clock;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // All core pulses last one cycle and are launched just after an edge.
    task automatic core(input logic wr, input logic rd, input logic [7:0] d, input logic mw,
                        input logic mv, input logic oc, input logic ic);
        @(posedge clock);
        #1;
        cpu_req = '{wdata: d, wr: wr, rd: rd};
        {mode_wr, mode_wdata, ovf_clr, irq_clr} = {mw, mv, oc, ic};
        @(posedge clock);
        #1;
        cpu_req = '{wdata: d, wr: 1'b0, rd: 1'b0};
        {mode_wr, mode_wdata, ovf_clr, irq_clr} = 4'h0;
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (slave_port_irq_flag !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk({7'h00, slave_port_irq_flag}, 8'h01, "irq flag");
    endtask
    initial begin
        #(5000 * 40);
        err_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_sim();
    end
    initial begin
        rstn = 1'b0;
        cpu_req = '0;
        {mode_wr, mode_wdata, ovf_clr, irq_clr, large_pkg, ext_prog_mem} = 6'h00;
        repeat (8) @(posedge clock);
        #1 rstn = 1'b1;
        chk(slave_port_control, 8'h00, "control at reset");
        chk(data_pin_oe_n, pslv_pkg::OE_N_OFF, "pins float at reset");
        u_host.write_cycle(8'h5a, 5);
        chk({7'h00, slave_port_irq_flag}, 8'h00, "no irq in plain mode");
        chk(slave_port_control, 8'h00, "control in plain mode");
        $display("test plain mode done");
        core(1'b0, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
        chk(slave_port_control, 8'h10, "mode bit");
        u_host.write_cycle(8'ha5, 5);
        wait_irq();
        chk(slave_port_control, 8'h90, "input full after write");
        chk(cpu_rdata, 8'ha5, "received word");
        u_host.write_cycle(8'h5c, 3);
        chk(slave_port_control, 8'hb0, "overflow on unread word");
        chk(cpu_rdata, 8'h5c, "second word");
        core(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
        chk(slave_port_control, 8'h90, "overflow cleared");
        core(1'b0, 1'b1, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(slave_port_control, 8'h10, "core read clears full");
        $display("test external write done");
        core(1'b1, 1'b0, 8'h3c, 1'b0, 1'b0, 1'b0, 1'b1);
        chk(slave_port_control, 8'h50, "output full on core write");
        fork
            u_host.read_cycle(10, rd_data);
            begin
                repeat (7) @(posedge clock);
                #1;
                chk(data_pin_in, 8'h3c, "latch driven on read");
                chk(data_pin_oe_n, 8'h00, "pins driven on read");
                core(1'b1, 1'b0, 8'hc3, 1'b0, 1'b0, 1'b0, 1'b0);
                chk(data_pin_in, 8'hc3, "new data mid read");
                chk(slave_port_control, 8'h50, "flags mid read");
            end
        join
        chk(rd_data, 8'hc3, "host sampled data");
        chk(data_pin_oe_n, pslv_pkg::OE_N_OFF, "pins float after read");
        chk({7'h00, slave_port_irq_flag}, 8'h01, "irq after read");
        $display("test external read done");
        core(1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
        {large_pkg, ext_prog_mem} = 2'b11;
        u_host.write_cycle(8'h77, 5);
        chk({7'h00, slave_port_irq_flag}, 8'h00, "no irq with external memory");
        chk(cpu_rdata, 8'hc3, "latch kept with external memory");
        ext_prog_mem = 1'b0;
        u_host.write_cycle(8'h77, 5);
        chk(cpu_rdata, 8'h77, "write on large package");
        chk(slave_port_control, 8'hd0, "flags on large package");
        $display("test package mode done");
        end_sim();
    end
endmodule // pslv_port_tb
